/* File: sleep_clock_gate_bank1.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - enable one clocks unit, zero stops it
// - access to gated unit answers bus fault
// - register resets to all zero
// - register sits at offset 0x114, read/write
// - sleep register used only in sleep
// - sleep gating needs automatic gating select
// - bit 24 gates comparator 0
// - bits 19..16 gate counters 3..0
// - bit 12 gates two-wire port 0
// - bits 5,4 gate sync serial 1,0
// - bits 2..0 gate async serial 2..0
// - unused bits read zero, ignore writes
module sleep_clock_gate_bank1 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [clock_gate_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [clock_gate_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire clock_gate_pkg::power_state_t power_state,
  input wire logic [31:0] run_clock_gate_ctrl1,
  input wire logic [31:0] deep_sleep_clock_gate_ctrl1,
  input wire logic [clock_gate_pkg::UNITS-1:0] unit_access,
  output logic [clock_gate_pkg::UNITS-1:0] unit_clk,
  output logic [clock_gate_pkg::UNITS-1:0] unit_access_ok,
  output logic [clock_gate_pkg::UNITS-1:0] unit_access_fault,
  output logic irq
);

  localparam int AW = clock_gate_pkg::ADDR_W;
  localparam int NU = clock_gate_pkg::UNITS;

  logic [31:0] sleep_clock_gate_ctrl1;
  logic [31:0] fault_enable;
  logic [31:0] fault_status;
  logic [31:0] fault_clear;
  logic [31:0] fault_set;
  logic [31:0] active_word;
  logic [31:0] wr_merged;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [NU-1:0] unit_en;
  logic aw_held;
  logic w_held;
  logic [AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_clear;
  logic wr_mapped;
  logic ar_hs;

  // ==========================================================
  // write channel capture, address and data in either order
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // ==========================================================
  // write decode and byte lane merge
  assign wr_ctrl = aw_addr_q == clock_gate_pkg::SLEEP_CTRL_OFF;
  assign wr_enable = aw_addr_q == clock_gate_pkg::FAULT_ENABLE_OFF;
  assign wr_clear = aw_addr_q == clock_gate_pkg::FAULT_CLEAR_OFF;
  assign wr_mapped = wr_ctrl || wr_enable || wr_clear ||
    (aw_addr_q == clock_gate_pkg::FAULT_STATUS_OFF);

  always_comb begin
    logic [31:0] base;
    base = 32'h0000_0000;
    if (wr_ctrl) begin
      base = sleep_clock_gate_ctrl1;
    end else if (wr_enable) begin
      base = fault_enable;
    end
    for (int b = 0; b < 4; b++) begin
      if (w_strb_q[b]) begin
        wr_merged[8*b +: 8] = w_data_q[8*b +: 8];
      end else begin
        wr_merged[8*b +: 8] = base[8*b +: 8];
      end
    end
  end

  // ==========================================================
  // gating register, fault enable register and fault clear pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_clock_gate_ctrl1 <= clock_gate_pkg::CTRL_RESET;
    end else if (wr_go && wr_ctrl) begin
      sleep_clock_gate_ctrl1 <= wr_merged & clock_gate_pkg::CTRL_WRITE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_enable <= clock_gate_pkg::CTRL_RESET;
    end else if (wr_go && wr_enable) begin
      fault_enable <= wr_merged & clock_gate_pkg::CTRL_WRITE_MASK;
    end
  end

  assign fault_clear = (wr_go && wr_clear) ?
    (wr_merged & clock_gate_pkg::CTRL_WRITE_MASK) : 32'h0000_0000;

  // ==========================================================
  // write response, unmapped address gets a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= clock_gate_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? clock_gate_pkg::RESP_OKAY :
        clock_gate_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // read channel
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rresp = clock_gate_pkg::RESP_OKAY;
    case (s_axi_araddr)
      clock_gate_pkg::SLEEP_CTRL_OFF: begin
        next_rdata = sleep_clock_gate_ctrl1;
      end
      clock_gate_pkg::FAULT_STATUS_OFF: begin
        next_rdata = fault_status;
      end
      clock_gate_pkg::FAULT_ENABLE_OFF: begin
        next_rdata = fault_enable;
      end
      clock_gate_pkg::FAULT_CLEAR_OFF: begin
        next_rdata = 32'h0000_0000;
      end
      default: begin
        next_rdata = 32'h0000_0000;
        next_rresp = clock_gate_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= clock_gate_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // choose the enable word for the present power mode
  always_comb begin
    if (!power_state.auto_clock_gating_select) begin
      active_word = run_clock_gate_ctrl1;
    end else begin
      case (power_state.mode)
        clock_gate_pkg::PM_SLEEP: begin
          active_word = sleep_clock_gate_ctrl1;
        end
        clock_gate_pkg::PM_DEEP_SLEEP: begin
          active_word = deep_sleep_clock_gate_ctrl1;
        end
        default: begin
          active_word = run_clock_gate_ctrl1;
        end
      endcase
    end
  end

  // ==========================================================
  // per unit gate, access check and fault event
  always_comb begin
    fault_set = 32'h0000_0000;
    for (int k = 0; k < NU; k++) begin
      fault_set[clock_gate_pkg::UNIT_BIT[k]] = unit_access[k] && !unit_en[k];
    end
  end

  for (genvar i = 0; i < NU; i++) begin : g_unit
    assign unit_en[i] = active_word[clock_gate_pkg::UNIT_BIT[i]];

    clock_gate_cell u_gate (
      .clk_in(aclk),
      .rst_n(aresetn),
      .enable(unit_en[i]),
      .gated_clk(unit_clk[i])
    );

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        unit_access_ok[i] <= 1'b0;
        unit_access_fault[i] <= 1'b0;
      end else begin
        unit_access_ok[i] <= unit_access[i] && unit_en[i];
        unit_access_fault[i] <= unit_access[i] && !unit_en[i];
      end
    end
  end

  fault_status_bank #(
    .W(32)
  ) u_status (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_evt(fault_set),
    .clear(fault_clear),
    .status(fault_status)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(fault_status & fault_enable);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ctrl_write_s;
    wr_go && wr_ctrl && (w_strb_q == 4'hF);
  endsequence

  sequence sleep_auto_s;
    power_state.auto_clock_gating_select &&
      (power_state.mode == clock_gate_pkg::PM_SLEEP);
  endsequence

  AST_RESET_CLEARS: assert property (
    $rose(aresetn) |-> (sleep_clock_gate_ctrl1 == clock_gate_pkg::CTRL_RESET))
    else $error("gating word not zero after reset");

  AST_CTRL_WRITE: assert property (
    ctrl_write_s |=> (sleep_clock_gate_ctrl1 ==
      ($past(w_data_q) & clock_gate_pkg::CTRL_WRITE_MASK)))
    else $error("gating word write not stored");

  AST_RESERVED_ZERO: assert property (
    (sleep_clock_gate_ctrl1 & ~clock_gate_pkg::CTRL_WRITE_MASK) == '0)
    else $error("reserved gating bit set");

  AST_SLEEP_USES_CTRL: assert property (
    sleep_auto_s |-> (unit_en[10] == sleep_clock_gate_ctrl1[24]) &&
      (unit_en[6] == sleep_clock_gate_ctrl1[16]) &&
      (unit_en[5] == sleep_clock_gate_ctrl1[12]))
    else $error("sleep mode not using sleep gating word");

  AST_NO_AUTO_RUN: assert property (
    !power_state.auto_clock_gating_select |->
      (unit_en[0] == run_clock_gate_ctrl1[0]) &&
      (unit_en[4] == run_clock_gate_ctrl1[5]))
    else $error("run word ignored without auto gating");

  AST_FAULT_GATED: assert property (
    |(unit_access & ~unit_en) |=>
      (unit_access_fault == ($past(unit_access) & ~$past(unit_en))))
    else $error("gated unit access not faulted");

  AST_OK_ENABLED: assert property (
    |unit_access |=>
      (unit_access_ok == ($past(unit_access) & $past(unit_en))) &&
      ((unit_access_ok & unit_access_fault) == '0))
    else $error("enabled unit access answer wrong");

  AST_READ_ANSWER: assert property (
    ar_hs && (s_axi_araddr == clock_gate_pkg::SLEEP_CTRL_OFF) |=>
      s_axi_rvalid && (s_axi_rdata == $past(sleep_clock_gate_ctrl1)))
    else $error("gating word read wrong");

  AST_WRITE_RESP: assert property (
    wr_go |=> s_axi_bvalid ##0
      (s_axi_bresp == ($past(wr_mapped) ? clock_gate_pkg::RESP_OKAY :
        clock_gate_pkg::RESP_SLVERR)))
    else $error("write response wrong");

  AST_IRQ_LEVEL: assert property (
    |(fault_status & fault_enable) |=> irq)
    else $error("interrupt not raised");

endmodule

`default_nettype wire

/* File: clock_gate_pkg.sv */
`default_nettype none

package clock_gate_pkg;

  // ==========================================================
  // bus and address map
  localparam int ADDR_W = 12;
  localparam logic [31:0] PERIPH_BASE = 32'h400F_E000;
  localparam logic [ADDR_W-1:0] SLEEP_CTRL_OFF = 12'h114;
  localparam logic [ADDR_W-1:0] FAULT_STATUS_OFF = 12'h200;
  localparam logic [ADDR_W-1:0] FAULT_ENABLE_OFF = 12'h204;
  localparam logic [ADDR_W-1:0] FAULT_CLEAR_OFF = 12'h208;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // gating word layout
  localparam int COMPARATOR0_BIT = 24;
  localparam int GP_COUNTER0_BIT = 16;
  localparam int GP_COUNTER1_BIT = 17;
  localparam int GP_COUNTER2_BIT = 18;
  localparam int GP_COUNTER3_BIT = 19;
  localparam int TWO_WIRE_PORT0_BIT = 12;
  localparam int SYNC_SERIAL_PORT1_BIT = 5;
  localparam int SYNC_SERIAL_PORT0_BIT = 4;
  localparam int ASYNC_SERIAL_PORT2_BIT = 2;
  localparam int ASYNC_SERIAL_PORT1_BIT = 1;
  localparam int ASYNC_SERIAL_PORT0_BIT = 0;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h010F_1037;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // ==========================================================
  // units, in ascending bit order
  localparam int UNITS = 11;
  localparam int UNIT_BIT [UNITS] = '{
    ASYNC_SERIAL_PORT0_BIT, ASYNC_SERIAL_PORT1_BIT,
    ASYNC_SERIAL_PORT2_BIT, SYNC_SERIAL_PORT0_BIT,
    SYNC_SERIAL_PORT1_BIT, TWO_WIRE_PORT0_BIT,
    GP_COUNTER0_BIT, GP_COUNTER1_BIT, GP_COUNTER2_BIT,
    GP_COUNTER3_BIT, COMPARATOR0_BIT
  };

  // ==========================================================
  // power state carrier
  typedef enum logic [1:0] {
    PM_RUN,
    PM_SLEEP,
    PM_DEEP_SLEEP
  } power_mode_t;

  typedef struct packed {
    logic auto_clock_gating_select;
    power_mode_t mode;
  } power_state_t;

endpackage

`default_nettype wire

/* File: clock_gate_cell.sv */
`timescale 1ns/1ps
`default_nettype none

module clock_gate_cell (
  input wire logic clk_in,
  input wire logic rst_n,
  input wire logic enable,
  output logic gated_clk
);

  logic en_q;

  // ==========================================================
  // enable moves only while the source clock is low
  always_ff @(negedge clk_in) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else begin
      en_q <= enable;
    end
  end

  assign gated_clk = clk_in & en_q;

  AST_GATE_HIGH_PHASE: assert property (@(negedge clk_in)
    disable iff (!rst_n) gated_clk == en_q)
    else $error("gated clock pulse cut short");

endmodule

`default_nettype wire

/* File: fault_status_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module fault_status_bank #(
  parameter int W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] clear,
  output logic [W-1:0] status
);

  // ==========================================================
  // sticky bits, a set in the clear cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= clock_gate_pkg::STATUS_RESET[W-1:0];
    end else begin
      status <= (status & ~clear) | set_evt;
    end
  end

  AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    |set_evt |=> ((status & $past(set_evt)) == $past(set_evt)))
    else $error("status event lost");

endmodule

`default_nettype wire

/* File: test_sleep_clock_gate_bank1.sv */
`timescale 1ns/1ps
`default_nettype none

module test_sleep_clock_gate_bank1;
  // ==========================================================
  // signals
  localparam int NU = clock_gate_pkg::UNITS;
  logic aclk;
  logic aresetn;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid, s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid, s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid, s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid, s_axi_rready;
  clock_gate_pkg::power_state_t power_state;
  logic [31:0] run_clock_gate_ctrl1;
  logic [31:0] deep_sleep_clock_gate_ctrl1;
  logic [NU-1:0] unit_access, unit_clk, unit_access_ok, unit_access_fault;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;

  sleep_clock_gate_bank1 i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .power_state(power_state),
    .run_clock_gate_ctrl1(run_clock_gate_ctrl1),
    .deep_sleep_clock_gate_ctrl1(deep_sleep_clock_gate_ctrl1),
    .unit_access(unit_access), .unit_clk(unit_clk),
    .unit_access_ok(unit_access_ok),
    .unit_access_fault(unit_access_fault), .irq(irq)
  );

  // ==========================================================
  // common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(32'(r), 32'(clock_gate_pkg::RESP_OKAY));
  endtask

  task automatic rd_exp(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, exp);
  endtask

  task automatic set_mode(input logic auto_sel,
                          input clock_gate_pkg::power_mode_t m);
    power_state <= '{auto_sel, m};
    repeat (3) @(posedge aclk);
  endtask

  task automatic access(input int i, input logic exp_ok);
    logic [NU-1:0] oh;
    oh = NU'(1) << i;
    unit_access <= oh;
    @(posedge aclk);
    unit_access <= '0;
    @(posedge aclk);
    check(32'(unit_access_ok), exp_ok ? 32'(oh) : 32'h0);
    check(32'(unit_access_fault), exp_ok ? 32'h0 : 32'(oh));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_and_fields();
    logic [31:0] d;
    logic [1:0] r;
    rd_exp(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h0000_0000);
    rd_exp(clock_gate_pkg::FAULT_STATUS_OFF, 32'h0000_0000);
    check(32'(irq), 32'h0);
    wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, 32'hFFFF_FFFF);
    rd_exp(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h010F_1037);
    s_axi_wstrb <= 4'h2;
    wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rd(clock_gate_pkg::SLEEP_CTRL_OFF, d, r);
    check(d, 32'h010F_0037);
    wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, d | 32'h0000_1000);
    rd_exp(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h010F_1037);
    wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, 32'hFEF0_EFC8);
    rd_exp(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h0000_0000);
  endtask

  task automatic t_mid_reset();
    wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, 32'hFFFF_FFFF);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_exp(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h0000_0000);
    check(32'(irq), 32'h0);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    rd(12'h118, d, r);
    check(32'(r), 32'(clock_gate_pkg::RESP_SLVERR));
    check(d, 32'h0);
    wr(12'h300, 32'h1234_5678, r);
    check(32'(r), 32'(clock_gate_pkg::RESP_SLVERR));
  endtask

  task automatic t_each_unit();
    logic [31:0] w;
    set_mode(1'b1, clock_gate_pkg::PM_SLEEP);
    for (int i = 0; i < NU; i++) begin
      w = 32'h1 << clock_gate_pkg::UNIT_BIT[i];
      wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, w);
      rd_exp(clock_gate_pkg::SLEEP_CTRL_OFF, w);
      access(i, 1'b1);
      access((i + 1) % NU, 1'b0);
      @(posedge aclk);
      #20;
      check(32'(unit_clk), 32'(NU'(1) << i));
      #40;
      check(32'(unit_clk), 32'h0);
      @(posedge aclk);
    end
  endtask

  task automatic t_mode_select();
    wr_ok(clock_gate_pkg::SLEEP_CTRL_OFF, 32'h0000_0000);
    run_clock_gate_ctrl1 <= 32'h010F_1037;
    deep_sleep_clock_gate_ctrl1 <= 32'h0000_0001;
    set_mode(1'b0, clock_gate_pkg::PM_SLEEP);
    access(0, 1'b1);
    set_mode(1'b1, clock_gate_pkg::PM_SLEEP);
    access(0, 1'b0);
    access(1, 1'b0);
    set_mode(1'b1, clock_gate_pkg::PM_DEEP_SLEEP);
    access(0, 1'b1);
    access(2, 1'b0);
    set_mode(1'b1, clock_gate_pkg::PM_RUN);
    access(2, 1'b1);
    run_clock_gate_ctrl1 <= 32'h0000_0000;
    set_mode(1'b1, clock_gate_pkg::PM_SLEEP);
  endtask

  task automatic t_fault_irq();
    wr_ok(clock_gate_pkg::FAULT_CLEAR_OFF, 32'hFFFF_FFFF);
    rd_exp(clock_gate_pkg::FAULT_STATUS_OFF, 32'h0000_0000);
    rd_exp(clock_gate_pkg::FAULT_CLEAR_OFF, 32'h0000_0000);
    wr_ok(clock_gate_pkg::FAULT_ENABLE_OFF, 32'h0000_0000);
    access(10, 1'b0);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    rd_exp(clock_gate_pkg::FAULT_STATUS_OFF, 32'h0100_0000);
    wr_ok(clock_gate_pkg::FAULT_ENABLE_OFF, 32'h0100_0000);
    rd_exp(clock_gate_pkg::FAULT_ENABLE_OFF, 32'h0100_0000);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h1);
    wr_ok(clock_gate_pkg::FAULT_CLEAR_OFF, 32'h0100_0000);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    rd_exp(clock_gate_pkg::FAULT_STATUS_OFF, 32'h0000_0000);
  endtask

  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    power_state = '{1'b1, clock_gate_pkg::PM_SLEEP};
    run_clock_gate_ctrl1 = 32'h0000_0000;
    deep_sleep_clock_gate_ctrl1 = 32'h0000_0000;
    unit_access = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_and_fields();
    t_mid_reset();
    t_unmapped();
    t_each_unit();
    t_mode_select();
    t_fault_irq();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
